// File: verilog/ipcs_regs.svh
// constants for the boot-time address selector
// assumes a 25 MHz device clock; counts are in cycles of that clock
`ifndef IPCS_REGS_SVH
`define IPCS_REGS_SVH

// ----------------------------------------------------------------------
// selector positions (low digit)
// ----------------------------------------------------------------------
`define IPCS_SEL_STORED_A 4'hC
`define IPCS_SEL_STORED_B 4'hD
`define IPCS_SEL_DISABLED 4'hF

// ----------------------------------------------------------------------
// derived configuration
// ----------------------------------------------------------------------
`define IPCS_NET_PREFIX   24'hC0_A864
`define IPCS_NET_MASK     32'hFFFF_FF00
`define IPCS_HOST_NETWORK 8'h00
`define IPCS_HOST_BCAST   8'hFF
`define IPCS_HOST_SUB_LO  8'h01
`define IPCS_HOST_SUB_HI  8'hFE

// ----------------------------------------------------------------------
// timing and counts
// ----------------------------------------------------------------------
`define IPCS_CLK_HZ       25000000
`define IPCS_FLASH_MS     200
`define IPCS_FLASH_CYC    ((`IPCS_CLK_HZ / 1000) * `IPCS_FLASH_MS)
`define IPCS_FLASH_COUNT  4
`define IPCS_PAUSE_PHASES 4
`define IPCS_SETTLE_CYC   4'h4
`define IPCS_AUTH_LIMIT   2'h3

`endif

// File: verilog/ipcs_pkg.sv
// types shared by the address selector, its store model and its test bench
// assumes ipcs_regs.svh provides the numeric constants
package ipcs_pkg;

   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] mask;
      logic [31:0] gw;
   } ipcs_netcfg_t;

   typedef enum logic [1:0] {
      IPCS_SRC_NONE,
      IPCS_SRC_STORED,
      IPCS_SRC_DERIVED
   } ipcs_src_t;

   typedef enum logic [1:0] {
      IPCS_ST_SETTLE,
      IPCS_ST_SAMPLE,
      IPCS_ST_RUN
   } ipcs_boot_t;

endpackage

// File: verilog/ipcs_led_flasher.sv
// status indicator flasher: a burst of flashes, then a pause, repeated
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`include "ipcs_regs.svh"

module ipcs_led_flasher #(
   parameter int TICK_CYC = `IPCS_FLASH_CYC
) (
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic enable,
   output logic      led_q
);

   localparam int NPH = 2 * `IPCS_FLASH_COUNT + `IPCS_PAUSE_PHASES;

   logic [31:0] tick_q, tick_d;
   logic [3:0]  phase_q, phase_d;
   logic        led_d;

   // ----------------------------------------------------------------------
   // phase sequencing
   // ----------------------------------------------------------------------
   always_comb begin
      tick_d  = tick_q;
      phase_d = phase_q;
      if (!enable) begin
         tick_d  = 32'h0000_0000;
         phase_d = 4'h0;
      end else if (tick_q == 32'(TICK_CYC - 1)) begin
         tick_d  = 32'h0000_0000;
         phase_d = (phase_q == 4'(NPH - 1)) ? 4'h0 : phase_q + 4'h1;
      end else begin
         tick_d = tick_q + 32'h0000_0001;
      end
      // even phases of the burst are lit, odd ones dark, then the pause
      led_d = enable && (phase_d < 4'(2 * `IPCS_FLASH_COUNT)) && !phase_d[0];
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         tick_q  <= 32'h0000_0000;
         phase_q <= 4'h0;
         led_q   <= 1'b0;
      end else begin
         tick_q  <= tick_d;
         phase_q <= phase_d;
         led_q   <= led_d;
      end
   end

endmodule

// File: verilog/ipcs_config_selector.sv
// boot-time network address selector with web access lockout and
// write-then-save handling of working parameters
// assumes selector pins are asynchronous; all other inputs are on clk
//
// Overview of operation
// - stored position loads address set from nonvolatile
// - changed configuration takes effect only after restart
// - disabled position derives address from hardware address
// - derived: fixed prefix, fixed mask, gateway equals address
// - derived host octet copies last hardware byte
// - hardware byte zero gives host octet one
// - hardware byte all ones gives 254
// - duplicate address flashes indicator in bursts of four, repeated until restart
// - three consecutive failed logins block main page
// - write updates working set; save commits; warn
// - positions C and D select stored mode
// - position F selects derived mode
`timescale 1ns/1ps
`include "ipcs_regs.svh"

module ipcs_config_selector
   import ipcs_pkg::*;
#(
   parameter int FLASH_TICK_CYC = `IPCS_FLASH_CYC
) (
   input  wire logic         clk,
   input  wire logic         srst,
   input  wire logic [3:0]   low_digit_selector,
   input  wire logic [3:0]   high_digit_selector,
   input  wire logic [7:0]   hw_addr_last,
   input  wire ipcs_netcfg_t nv_cfg,
   input  wire logic         web_wr_valid,
   input  wire ipcs_netcfg_t web_wr_cfg,
   input  wire logic         web_save_req,
   input  wire logic         auth_try,
   input  wire logic         auth_ok,
   input  wire logic         dup_detect,
   output ipcs_netcfg_t      own_cfg_q,
   output logic              cfg_valid_q,
   output ipcs_src_t         cfg_src_q,
   output ipcs_netcfg_t      work_cfg_q,
   output logic              unsaved_q,
   output logic              nv_wr_en_q,
   output ipcs_netcfg_t      nv_wr_cfg_q,
   output logic              access_grant_q,
   output logic              locked_q,
   output logic              dup_err_q,
   output logic              status_led_q
);

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   function automatic logic [7:0] host_octet(input logic [7:0] b);
      if (b == `IPCS_HOST_NETWORK)
         return `IPCS_HOST_SUB_LO;
      else if (b == `IPCS_HOST_BCAST)
         return `IPCS_HOST_SUB_HI;
      return b;
   endfunction

   function automatic ipcs_netcfg_t derive_cfg(input logic [7:0] b);
      ipcs_netcfg_t c;
      c.addr = {`IPCS_NET_PREFIX, host_octet(b)};
      c.mask = `IPCS_NET_MASK;
      c.gw   = c.addr;
      return c;
   endfunction

   // ----------------------------------------------------------------------
   // selector synchronisers
   // ----------------------------------------------------------------------
   // high digit is unused in both supported modes; beyond the stability compare it is only synchronised
   // so that a later mode can read it without a new crossing
   logic [7:0] sel_s1_q, sel_s2_q, sel_s3_q, sel_st_q, sel_st_d;

   always_comb begin
      sel_st_d = (sel_s2_q == sel_s3_q) ? sel_s3_q : sel_st_q;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         sel_s1_q <= 8'h00;
         sel_s2_q <= 8'h00;
         sel_s3_q <= 8'h00;
         sel_st_q <= 8'h00;
      end else begin
         sel_s1_q <= {high_digit_selector, low_digit_selector};
         sel_s2_q <= sel_s1_q;
         sel_s3_q <= sel_s2_q;
         sel_st_q <= sel_st_d;
      end
   end

   wire logic [3:0] sel_lo = sel_st_q[3:0];

   // ----------------------------------------------------------------------
   // boot sequencing and active configuration
   // ----------------------------------------------------------------------
   // settle lets the three-stage pipe fill before the one and only sample
   ipcs_boot_t   st_q, st_d;
   logic [3:0]   settle_q, settle_d;
   ipcs_netcfg_t own_cfg_d;
   logic         cfg_valid_d;
   ipcs_src_t    cfg_src_d;

   always_comb begin
      st_d        = st_q;
      settle_d    = settle_q;
      own_cfg_d   = own_cfg_q;
      cfg_valid_d = cfg_valid_q;
      cfg_src_d   = cfg_src_q;
      case (st_q)
         IPCS_ST_SETTLE: begin
            settle_d = settle_q + 4'h1;
            if (settle_q == `IPCS_SETTLE_CYC)
               st_d = IPCS_ST_SAMPLE;
         end
         IPCS_ST_SAMPLE: begin
            st_d = IPCS_ST_RUN;
            if (sel_lo == `IPCS_SEL_STORED_A || sel_lo == `IPCS_SEL_STORED_B) begin
               own_cfg_d   = nv_cfg;
               cfg_valid_d = 1'b1;
               cfg_src_d   = IPCS_SRC_STORED;
            end else if (sel_lo == `IPCS_SEL_DISABLED) begin
               own_cfg_d   = derive_cfg(hw_addr_last);
               cfg_valid_d = 1'b1;
               cfg_src_d   = IPCS_SRC_DERIVED;
            end
         end
         IPCS_ST_RUN: begin
            // web writes never reach the active set until a restart
            st_d = IPCS_ST_RUN;
         end
         default: st_d = IPCS_ST_SETTLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_q        <= IPCS_ST_SETTLE;
         settle_q    <= 4'h0;
         own_cfg_q   <= '0;
         cfg_valid_q <= 1'b0;
         cfg_src_q   <= IPCS_SRC_NONE;
      end else begin
         st_q        <= st_d;
         settle_q    <= settle_d;
         own_cfg_q   <= own_cfg_d;
         cfg_valid_q <= cfg_valid_d;
         cfg_src_q   <= cfg_src_d;
      end
   end

   // ----------------------------------------------------------------------
   // working parameters, save and unsaved warning
   // ----------------------------------------------------------------------
   ipcs_netcfg_t work_cfg_d, nv_wr_cfg_d;
   logic         unsaved_d, nv_wr_en_d;

   always_comb begin
      work_cfg_d  = work_cfg_q;
      nv_wr_cfg_d = nv_wr_cfg_q;
      nv_wr_en_d  = 1'b0;
      unsaved_d   = unsaved_q;
      if (st_q == IPCS_ST_SAMPLE)
         work_cfg_d = nv_cfg;
      if (web_save_req) begin
         nv_wr_en_d  = 1'b1;
         nv_wr_cfg_d = web_wr_valid ? web_wr_cfg : work_cfg_q;
         unsaved_d   = 1'b0;
      end
      // a write in the save cycle is committed with it, so no warning remains
      if (web_wr_valid) begin
         work_cfg_d = web_wr_cfg;
         unsaved_d  = !web_save_req;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         work_cfg_q  <= '0;
         nv_wr_cfg_q <= '0;
         nv_wr_en_q  <= 1'b0;
         unsaved_q   <= 1'b0;
      end else begin
         work_cfg_q  <= work_cfg_d;
         nv_wr_cfg_q <= nv_wr_cfg_d;
         nv_wr_en_q  <= nv_wr_en_d;
         unsaved_q   <= unsaved_d;
      end
   end

   // ----------------------------------------------------------------------
   // login lockout and duplicate address flag
   // ----------------------------------------------------------------------
   // lockout lasts until restart: no unlock path exists on purpose
   logic [1:0] fail_cnt_q, fail_cnt_d;
   logic       locked_d, grant_d, dup_err_d;

   always_comb begin
      fail_cnt_d = fail_cnt_q;
      locked_d   = locked_q;
      grant_d    = 1'b0;
      dup_err_d  = dup_err_q || dup_detect;
      if (auth_try && !locked_q) begin
         if (auth_ok) begin
            grant_d    = 1'b1;
            fail_cnt_d = 2'h0;
         end else begin
            fail_cnt_d = fail_cnt_q + 2'h1;
            if (fail_cnt_d == `IPCS_AUTH_LIMIT)
               locked_d = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         fail_cnt_q     <= 2'h0;
         locked_q       <= 1'b0;
         access_grant_q <= 1'b0;
         dup_err_q      <= 1'b0;
      end else begin
         fail_cnt_q     <= fail_cnt_d;
         locked_q       <= locked_d;
         access_grant_q <= grant_d;
         dup_err_q      <= dup_err_d;
      end
   end

   ipcs_led_flasher #(
      .TICK_CYC (FLASH_TICK_CYC)
   ) u_flasher (
      .clk    (clk),
      .srst   (srst),
      .enable (dup_err_q),
      .led_q  (status_led_q)
   );

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   sequence s_sample_stored;
      st_q == IPCS_ST_SAMPLE &&
      (sel_lo == `IPCS_SEL_STORED_A || sel_lo == `IPCS_SEL_STORED_B);
   endsequence

   sequence s_sample_derived;
      st_q == IPCS_ST_SAMPLE && sel_lo == `IPCS_SEL_DISABLED;
   endsequence

   chk_stored_load: assert property (
      s_sample_stored |=> own_cfg_q == $past(nv_cfg) && cfg_src_q == IPCS_SRC_STORED)
      else $error("stored position did not load nonvolatile set");

   chk_derived_shape: assert property (
      s_sample_derived |=> own_cfg_q.addr[31:8] == 24'hC0_A864 &&
         own_cfg_q.mask == 32'hFFFF_FF00 && own_cfg_q.gw == own_cfg_q.addr)
      else $error("derived configuration malformed");

   chk_host_copy: assert property (
      s_sample_derived ##0 (hw_addr_last != 8'h00 && hw_addr_last != 8'hFF)
      |=> own_cfg_q.addr[7:0] == $past(hw_addr_last))
      else $error("host octet not copied");

   chk_host_zero: assert property (
      s_sample_derived ##0 hw_addr_last == 8'h00 |=> own_cfg_q.addr[7:0] == 8'h01)
      else $error("zero byte not replaced by one");
   chk_host_ones: assert property (
      s_sample_derived ##0 hw_addr_last == 8'hFF |=> own_cfg_q.addr[7:0] == 8'hFE)
      else $error("all-ones byte not replaced by 254");
   chk_cfg_hold: assert property (
      st_q == IPCS_ST_RUN |=> st_q == IPCS_ST_RUN && $stable(own_cfg_q))
      else $error("active configuration changed after boot");
   chk_lock_third: assert property (
      auth_try && !auth_ok && !locked_q && fail_cnt_q == 2'h2 |=> locked_q ##1 locked_q)
      else $error("third failure did not lock");
   chk_no_grant_locked: assert property (
      locked_q |=> !access_grant_q)
      else $error("access granted while locked");
   chk_save_commit: assert property (
      web_save_req && !web_wr_valid |=> nv_wr_en_q && !unsaved_q &&
         nv_wr_cfg_q == $past(work_cfg_q))
      else $error("save did not commit working set");
   chk_write_warn: assert property (
      web_wr_valid |=> unsaved_q == !$past(web_save_req) && work_cfg_q == $past(web_wr_cfg))
      else $error("write warning or working set wrong");
   chk_dup_flag: assert property (
      dup_detect |=> dup_err_q [*3])
      else $error("duplicate address flag not held");

endmodule

// File: verification/ipcs_store_model.sv
// far-side model: the nonvolatile store that saved parameters land in
// assumes commits arrive as one-cycle strobes on the device clock
`timescale 1ns/1ps

module ipcs_store_model
   import ipcs_pkg::*;
#(
   parameter ipcs_netcfg_t INIT_CFG = '0
) (
   input  wire logic         clk,
   input  wire logic         nv_wr_en,
   input  wire ipcs_netcfg_t nv_wr_cfg,
   output ipcs_netcfg_t      nv_cfg,
   output logic [7:0]        commit_cnt
);
   // ----------------------------------------------------------------
   // store
   // ----------------------------------------------------------------
   // contents survive a device reset, so srst is not seen here
   initial begin
      nv_cfg = INIT_CFG;
      commit_cnt = 8'h00;
   end

   // each strobe cycle commits once, so a wide strobe shows as extra commits
   always @(posedge clk) begin
      if (nv_wr_en === 1'b1) begin
         nv_cfg <= nv_wr_cfg;
         commit_cnt <= commit_cnt + 8'h01;
      end
   end
endmodule

// File: verification/ipcs_config_selector_test.sv
// self-checking bench for the boot-time address selector
// assumes ipcs_store_model stands in for the nonvolatile store
`timescale 1ns/1ps

module ipcs_config_selector_test;
   import ipcs_pkg::*;

   // ----------------------------------------------------------------
   // set-up
   // ----------------------------------------------------------------
   localparam int TICK = 4;
   localparam ipcs_netcfg_t NV0 = {32'h0A00_0005, 32'hFFFF_0000, 32'h0A00_0001};
   localparam ipcs_netcfg_t NEW = {32'h0A00_0077, 32'hFFFF_FF00, 32'h0A00_00FE};
   localparam logic [7:0] HW[6] = '{8'h06, 8'hA7, 8'h00, 8'hFF, 8'h01, 8'hFE};
   localparam logic [7:0] HOST[6] = '{8'h06, 8'hA7, 8'h01, 8'hFE, 8'h01, 8'hFE};
   localparam logic [3:0] BAD[3] = '{4'h0, 4'hA, 4'hE};

   logic clk, srst, web_wr_valid, web_save_req, auth_try, auth_ok, dup_detect;
   logic [3:0]   low_digit_selector, high_digit_selector;
   logic [7:0]   hw_addr_last, commit_cnt;
   ipcs_netcfg_t nv_cfg, web_wr_cfg, own_cfg_q, work_cfg_q, nv_wr_cfg_q;
   ipcs_src_t    cfg_src_q;
   logic cfg_valid_q, unsaved_q, nv_wr_en_q, access_grant_q, locked_q;
   logic dup_err_q, status_led_q, grant, prev;
   int   fails, compares, rises, highs;

   ipcs_config_selector #(.FLASH_TICK_CYC(TICK)) u_ipcs_config_selector (
      .clk(clk), .srst(srst), .low_digit_selector(low_digit_selector),
      .high_digit_selector(high_digit_selector), .hw_addr_last(hw_addr_last),
      .nv_cfg(nv_cfg), .web_wr_valid(web_wr_valid), .web_wr_cfg(web_wr_cfg),
      .web_save_req(web_save_req), .auth_try(auth_try), .auth_ok(auth_ok),
      .dup_detect(dup_detect), .own_cfg_q(own_cfg_q), .cfg_valid_q(cfg_valid_q),
      .cfg_src_q(cfg_src_q), .work_cfg_q(work_cfg_q), .unsaved_q(unsaved_q),
      .nv_wr_en_q(nv_wr_en_q), .nv_wr_cfg_q(nv_wr_cfg_q),
      .access_grant_q(access_grant_q), .locked_q(locked_q),
      .dup_err_q(dup_err_q), .status_led_q(status_led_q));

   ipcs_store_model #(.INIT_CFG(NV0)) u_ipcs_store_model (
      .clk(clk), .nv_wr_en(nv_wr_en_q), .nv_wr_cfg(nv_wr_cfg_q),
      .nv_cfg(nv_cfg), .commit_cnt(commit_cnt));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [95:0] seen,
                        input logic [95:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic final_report();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // pins are set while reset is held; the sync pipe refills before the sample state
   task automatic boot(input logic [3:0] lo, input logic [3:0] hi, input logic [7:0] hw);
      @(posedge clk);
      srst <= 1'b1;
      low_digit_selector <= lo;
      high_digit_selector <= hi;
      hw_addr_last <= hw;
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      repeat (20) begin
         @(posedge clk);
         #1;
         if (cfg_valid_q === 1'b1) break;
      end
   endtask

   task automatic web_write(input ipcs_netcfg_t cfg);
      @(posedge clk);
      web_wr_valid <= 1'b1;
      web_wr_cfg <= cfg;
      @(posedge clk);
      web_wr_valid <= 1'b0;
      @(posedge clk);
      #1;
   endtask

   task automatic save();
      @(posedge clk);
      web_save_req <= 1'b1;
      @(posedge clk);
      web_save_req <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
   endtask

   // grant is a one-cycle pulse, so both candidate cycles are looked at
   task automatic login(input logic ok, output logic seen);
      @(posedge clk);
      auth_try <= 1'b1;
      auth_ok <= ok;
      @(posedge clk);
      auth_try <= 1'b0;
      #1 seen = access_grant_q;
      @(posedge clk);
      #1 seen = seen | access_grant_q;
   endtask

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      {srst, web_wr_valid, web_save_req, auth_try, auth_ok, dup_detect} = 6'b10_0000;
      {low_digit_selector, high_digit_selector, hw_addr_last} = 16'h0000;
      web_wr_cfg = '0;
      fails = 0;
      compares = 0;
      boot(4'hC, 4'h9, 8'h33);
      check("stored cfg", own_cfg_q, NV0);
      check("stored src", cfg_src_q, IPCS_SRC_STORED);
      check("stored valid", cfg_valid_q, 1'b1);
      check("led idle", {dup_err_q, status_led_q}, 2'b00);
      @(posedge clk);
      low_digit_selector <= 4'hF;
      hw_addr_last <= 8'h44;
      repeat (12) @(posedge clk);
      #1 check("held cfg", own_cfg_q, NV0);
      check("held src", cfg_src_q, IPCS_SRC_STORED);
      web_write(NEW);
      check("work cfg", work_cfg_q, NEW);
      check("unsaved set", unsaved_q, 1'b1);
      check("cfg not live", own_cfg_q, NV0);
      check("no commit", commit_cnt, 8'h00);
      save();
      check("unsaved clr", unsaved_q, 1'b0);
      check("one commit", commit_cnt, 8'h01);
      check("stored new", nv_cfg, NEW);
      boot(4'hD, 4'h0, 8'h33);
      check("restart cfg", own_cfg_q, NEW);
      for (int i = 0; i < 6; i++) begin
         boot(4'hF, 4'(i), HW[i]);
         check("derived cfg", own_cfg_q, {24'hC0_A864, HOST[i], 32'hFFFF_FF00,
               24'hC0_A864, HOST[i]});
         check("derived src", cfg_src_q, IPCS_SRC_DERIVED);
      end
      foreach (BAD[i]) begin
         boot(BAD[i], 4'hC, 8'h10);
         check("no cfg", {cfg_valid_q, cfg_src_q}, {1'b0, IPCS_SRC_NONE});
      end
      login(1'b1, grant);
      check("grant ok", grant, 1'b1);
      login(1'b0, grant);
      login(1'b0, grant);
      login(1'b1, grant);
      check("grant after 2", grant, 1'b1);
      login(1'b0, grant);
      login(1'b0, grant);
      check("not locked", locked_q, 1'b0);
      login(1'b0, grant);
      check("locked", locked_q, 1'b1);
      login(1'b1, grant);
      check("no grant", grant, 1'b0);
      @(posedge clk);
      {web_wr_valid, web_save_req} <= 2'b11;
      web_wr_cfg <= NV0;
      @(posedge clk);
      {web_wr_valid, web_save_req} <= 2'b00;
      @(posedge clk);
      #1 check("both unsaved", unsaved_q, 1'b0);
      check("both data", nv_wr_cfg_q, NV0);
      check("two commits", commit_cnt, 8'h02);
      @(posedge clk);
      dup_detect <= 1'b1;
      @(posedge clk);
      dup_detect <= 1'b0;
      @(posedge clk);
      #1 check("dup err", dup_err_q, 1'b1);
      check("led on", status_led_q, 1'b1);
      // the lit phase that starts with the flag is one cycle short: count from the next
      repeat (2) @(posedge clk);
      #1 prev = status_led_q;
      rises = 0;
      highs = 0;
      // two full flash cycles of 12 phases, each phase TICK cycles long
      repeat (24 * TICK) begin
         @(posedge clk);
         #1;
         if (status_led_q === 1'b1) highs++;
         if (status_led_q === 1'b1 && prev === 1'b0) rises++;
         prev = status_led_q;
      end
      check("led flashes", rises, 8);
      check("led lit", highs, 8 * TICK);
      final_report();
   end

   initial begin
      repeat (8000) @(posedge clk);
      fails++;
      final_report();
   end
endmodule
